// ===== rtl/udma_rx_pkg.sv
// constants for the ultra dma receive error/status block
// assumes a single 100 MHz clock domain
package udma_rx_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [15:0] FIFO_WRITE_POINTER_LOW_ADDR = 16'hf0eb;
  localparam logic [15:0] FIFO_WRITE_POINTER_HIGH_ADDR = 16'hf0ec;
  localparam logic [15:0] ERROR_STATUS_ADDR = 16'hf0e0;
  localparam logic [15:0] EXCESS_WORD_COUNT_ADDR = 16'hf0e1;
  localparam logic [15:0] CONFIG_ADDR = 16'hf0e2;
  localparam int unsigned AUX_OVERFLOW_BIT = 4;
  localparam int unsigned SYNC_OVERRUN_BIT = 5;
  localparam int unsigned EXCESS_RECEIVE_BIT = 6;
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned TRANSFER_START_BIT = 1;
  localparam int unsigned AUX_BUFFER_BYTES = 6;
  localparam int unsigned PTR_W = 14;
  localparam int unsigned COUNT_W = 14;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [13:0] PTR_RESET = 14'h0000;
endpackage

// ===== rtl/word_skid_buffer.sv
// two-entry valid/ready buffer in the sector fifo write path
// assumes source and sink share clk
`timescale 1ns/1ps
module word_skid_buffer
  import udma_rx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  logic [15:0] mem_reg [2];
  logic rd_reg;
  logic wr_reg;
  logic [1:0] count_reg;

  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (in_valid && in_ready) begin
        mem_reg[wr_reg] <= in_data;
        wr_reg <= ~wr_reg;
      end
      if (out_valid && out_ready) begin
        rd_reg <= ~rd_reg;
      end
      count_reg <= count_reg + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end
  end
endmodule

// ===== rtl/udma_rx_error_status.sv
// error flags, excess word count and fifo write pointer for udma receive
// assumes the transfer engine supplies per-word strobes on clk
// Functional notes
// (R01) a one written to soft reset or transfer start clears the aux buffer overflow flag.
// (R02) in udma reads a sync buffer overrun sets status bit 5.
// (R03) soft reset or transfer start clears the sync buffer overrun flag.
// (R04) in udma reads a word after the expected count sets status bit 6.
// (R05) excess data is counted in 2-byte words in a readable count register.
// (R06) excess words are dropped and never written to the sector fifo.
// (R07) excess words still feed the running udma crc until the burst ends.
// (R08) a drive that stopped at termination may see no crc error for that burst.
// (R09) the low byte of the fifo write pointer is a read-only byte resetting to 00h.
// (R10) more than six bytes pushed into the aux buffer sets the overflow flag.
// (R11) the write pointer is 14 bits, upper six bits in a companion byte.
// (R12) flags stay set until cleared and reads do not change them.
`timescale 1ns/1ps
module udma_rx_error_status
  import udma_rx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // xdata register port
  input wire logic [15:0] xaddr,
  input wire logic xwr,
  input wire logic xrd,
  input wire logic [7:0] xwdata,
  output logic [7:0] xrdata,
  // transfer engine events
  input wire logic udma_read_mode,
  input wire logic sync_overrun_evt,
  input wire logic aux_push_valid,
  input wire logic [2:0] aux_push_bytes,
  input wire logic aux_pop,
  input wire logic expected_done,
  input wire logic burst_end,
  // received words from the link
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  output logic rx_ready,
  // sector fifo write side
  output logic fifo_valid,
  input wire logic fifo_ready,
  output logic [15:0] fifo_data,
  // crc feed
  output logic crc_valid,
  output logic [15:0] crc_data,
  // control out
  output logic soft_reset_pulse,
  output logic transfer_start_ctl
);
  // ****************************************
  // register decode
  // ****************************************
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  logic clear_cmd;
  logic aux_buffer_overflow_flag_reg;
  logic sync_buffer_overrun_flag_reg;
  logic excess_receive_flag_reg;
  logic [COUNT_W-1:0] excess_word_count_reg;
  logic [PTR_W-1:0] fifo_write_pointer_reg;
  logic [3:0] aux_level_reg;
  logic in_burst_reg;
  logic excess_word;
  logic buf_in_ready;

  assign clear_cmd = xwr && hit(xaddr, CONFIG_ADDR)
    && (xwdata[SOFT_RESET_BIT] || xwdata[TRANSFER_START_BIT]); // R01 R03

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
      transfer_start_ctl <= 1'b0;
    end else begin
      soft_reset_pulse <= xwr && hit(xaddr, CONFIG_ADDR) && xwdata[SOFT_RESET_BIT];
      transfer_start_ctl <= xwr && hit(xaddr, CONFIG_ADDR) && xwdata[TRANSFER_START_BIT];
    end
  end

  // ****************************************
  // error flags
  // ****************************************
  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_level_reg <= 4'd0;
      aux_buffer_overflow_flag_reg <= 1'b0;
    end else begin
      if (clear_cmd) begin
        aux_level_reg <= 4'd0;
      end else if (aux_push_valid) begin
        aux_level_reg <= aux_level_reg + 4'(aux_push_bytes);
      end else if (aux_pop) begin
        aux_level_reg <= 4'd0;
      end
      if (aux_push_valid && (5'(aux_level_reg) + 5'(aux_push_bytes) > 5'(AUX_BUFFER_BYTES))) begin
        aux_buffer_overflow_flag_reg <= 1'b1; // R10
      end else if (clear_cmd) begin
        aux_buffer_overflow_flag_reg <= 1'b0; // R01 R12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_buffer_overrun_flag_reg <= 1'b0;
    end else if (udma_read_mode && sync_overrun_evt) begin
      sync_buffer_overrun_flag_reg <= 1'b1; // R02
    end else if (clear_cmd) begin
      sync_buffer_overrun_flag_reg <= 1'b0; // R03 R12
    end
  end

  // ****************************************
  // excess receive handling
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_burst_reg <= 1'b0;
    end else if (clear_cmd || burst_end) begin
      in_burst_reg <= 1'b0;
    end else if (expected_done) begin
      in_burst_reg <= 1'b1;
    end
  end

  assign excess_word = udma_read_mode && in_burst_reg && rx_valid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      excess_receive_flag_reg <= 1'b0;
      excess_word_count_reg <= '0;
    end else if (excess_word) begin
      excess_receive_flag_reg <= 1'b1; // R04
      excess_word_count_reg <= excess_word_count_reg + 1'b1; // R05
    end else if (clear_cmd) begin
      excess_receive_flag_reg <= 1'b0; // R12
      excess_word_count_reg <= '0;
    end
  end

  // excess words are always accepted so the drive is never stalled
  assign rx_ready = in_burst_reg ? 1'b1 : buf_in_ready;

  word_skid_buffer u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_valid && !in_burst_reg), // R06
    .in_ready(buf_in_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // crc sees every accepted word, excess included; R08 follows from this
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_valid <= 1'b0;
      crc_data <= 16'h0000;
    end else begin
      crc_valid <= rx_valid && rx_ready; // R07 R08
      crc_data <= rx_data;
    end
  end

  // ****************************************
  // write pointer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_write_pointer_reg <= PTR_RESET; // R09
    end else if (fifo_valid && fifo_ready) begin
      fifo_write_pointer_reg <= fifo_write_pointer_reg + 1'b1; // R11
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    xrdata = BYTE_RESET;
    if (xrd) begin
      if (hit(xaddr, FIFO_WRITE_POINTER_LOW_ADDR)) begin
        xrdata = fifo_write_pointer_reg[7:0]; // R09
      end else if (hit(xaddr, FIFO_WRITE_POINTER_HIGH_ADDR)) begin
        xrdata = {2'b00, fifo_write_pointer_reg[13:8]}; // R11
      end else if (hit(xaddr, ERROR_STATUS_ADDR)) begin
        xrdata[AUX_OVERFLOW_BIT] = aux_buffer_overflow_flag_reg;
        xrdata[SYNC_OVERRUN_BIT] = sync_buffer_overrun_flag_reg;
        xrdata[EXCESS_RECEIVE_BIT] = excess_receive_flag_reg;
      end else if (hit(xaddr, EXCESS_WORD_COUNT_ADDR)) begin
        xrdata = excess_word_count_reg[7:0]; // R05
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_sync_set;
    @(posedge clk) disable iff (!rst_n)
      udma_read_mode && sync_overrun_evt |=> sync_buffer_overrun_flag_reg;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync flag not set"); // R02

  property p_sync_clr;
    @(posedge clk) disable iff (!rst_n)
      clear_cmd && !(udma_read_mode && sync_overrun_evt) |=> !sync_buffer_overrun_flag_reg;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync flag not cleared"); // R03

  property p_aux_clr;
    @(posedge clk) disable iff (!rst_n)
      clear_cmd && !aux_push_valid |=> !aux_buffer_overflow_flag_reg;
  endproperty
  a_aux_clr: assert property (p_aux_clr) else $error("overflow flag not cleared"); // R01

  property p_excess_set;
    @(posedge clk) disable iff (!rst_n)
      excess_word |=> excess_receive_flag_reg
        && excess_word_count_reg == $past(excess_word_count_reg) + 1'b1;
  endproperty
  a_excess_set: assert property (p_excess_set) else $error("excess not counted"); // R04 R05

  property p_no_fifo;
    @(posedge clk) disable iff (!rst_n)
      in_burst_reg && rx_valid |=> $stable(u_buf.count_reg) || $fell(u_buf.count_reg != 0)
        || u_buf.count_reg < $past(u_buf.count_reg);
  endproperty
  a_no_fifo: assert property (p_no_fifo) else $error("excess word reached fifo"); // R06

  property p_crc;
    @(posedge clk) disable iff (!rst_n)
      excess_word |=> crc_valid && crc_data == $past(rx_data);
  endproperty
  a_crc: assert property (p_crc) else $error("excess word missed crc"); // R07

  property p_ptr;
    @(posedge clk) disable iff (!rst_n)
      fifo_valid && fifo_ready |=> fifo_write_pointer_reg == $past(fifo_write_pointer_reg) + 1'b1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer did not advance"); // R11

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      sync_buffer_overrun_flag_reg && !clear_cmd |=> sync_buffer_overrun_flag_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear"); // R12
endmodule

// ===== testbench/ata_drive_model.sv
// drive model: storage device sending udma read words
// assumes the bench samples on rising clk edges
`timescale 1ns/1ps
module ata_drive_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and link
  input wire logic en,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data
);
  // ****************
  // word source
  // ****************
  int seed = 1;
  logic took;
  initial begin
    rx_valid = 1'b0;
    rx_data = 16'h0000;
  end
  always @(posedge clk) took <= rx_valid && rx_ready;
  // idle data keeps moving so a stale word never passes for a fresh one
  always @(negedge clk) begin
    if (!rst_n) rx_valid <= 1'b0;
    else if (took || !rx_valid) rx_valid <= en && (($random(seed) % 3) != 0);
    if (took || !rx_valid) rx_data <= 16'($random(seed));
  end
endmodule

// ===== testbench/udma_rx_error_status_bench.sv
// bench for the udma receive error/status block
// assumes the drive model and the design package are compiled first
`timescale 1ns/1ps
module udma_rx_error_status_bench;
  import udma_rx_pkg::*;
  logic clk, rst_n, xwr, xrd, rx_valid, rx_ready, fifo_valid, fifo_ready;
  logic crc_valid, en, udma, excess, srp, tsc;
  logic [15:0] xaddr, rx_data, fifo_data, crc_data, last_rx;
  logic [7:0] xwdata, xrdata;
  logic [2:0] nbytes;
  logic [4:0] ev;
  int fails, checks, seed, acc, crcn, n0, n1, nfifo;
  logic [15:0] expq[$];
  // ****************
  // structure
  // ****************
  udma_rx_error_status DUT (.clk(clk), .rst_n(rst_n), .xaddr(xaddr), .xwr(xwr),
    .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata), .udma_read_mode(udma),
    .sync_overrun_evt(ev[4]), .aux_push_valid(ev[3]), .aux_push_bytes(nbytes),
    .aux_pop(ev[2]), .expected_done(ev[1]), .burst_end(ev[0]), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .fifo_data(fifo_data), .crc_valid(crc_valid),
    .crc_data(crc_data), .soft_reset_pulse(srp), .transfer_start_ctl(tsc));
  ata_drive_model model (.clk(clk), .rst_n(rst_n), .en(en), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge clk);
    xaddr = a;
    xrd = 1'b1;
    // sampled a full cycle later so every input changes on a falling edge
    @(negedge clk);
    chk("xrdata", {8'h00, e}, {8'h00, xrdata & m});
    xrd = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    xaddr = a;
    xwdata = d;
    xwr = 1'b1;
    @(negedge clk);
    xwr = 1'b0;
  endtask
  task automatic fire(input logic [4:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 5'h00;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // words taken in the excess phase must never reach the fifo
  always @(posedge clk) begin
    if (crc_valid === 1'b1) begin
      crcn++;
      chk("crc_data", last_rx, crc_data);
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      acc++;
      last_rx = rx_data;
      if (!excess) expq.push_back(rx_data);
    end
    if (fifo_valid === 1'b1 && fifo_ready) begin
      nfifo++;
      if (expq.size() > 0) chk("fifo_data", expq.pop_front(), fifo_data);
      else chk("fifo_extra", 16'h0000, 16'h0001);
    end
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
  // ****************
  // sequence
  // ****************
  initial begin
    rst_n = 1'b0;
    xaddr = 16'h0000;
    xwr = 1'b0;
    xrd = 1'b0;
    xwdata = 8'h00;
    nbytes = 3'd0;
    ev = 5'h00;
    udma = 1'b0;
    excess = 1'b0;
    en = 1'b0;
    fifo_ready = 1'b0;
    seed = 1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(FIFO_WRITE_POINTER_LOW_ADDR, 8'hff, BYTE_RESET);
    wr(FIFO_WRITE_POINTER_LOW_ADDR, 8'h5a);
    rd(FIFO_WRITE_POINTER_LOW_ADDR, 8'hff, BYTE_RESET);
    rd(ERROR_STATUS_ADDR, 8'hf0, 8'h00);
    rd(16'hf0ff, 8'hff, 8'h00);
    en = 1'b1;
    repeat (12) @(negedge clk);
    chk("accepted", 16'd2, acc[15:0]);
    repeat (300) begin
      @(negedge clk);
      fifo_ready = 1'($random(seed));
    end
    en = 1'b0;
    fifo_ready = 1'b1;
    repeat (8) @(negedge clk);
    chk("drained", 16'd0, 16'(expq.size()));
    rd(FIFO_WRITE_POINTER_LOW_ADDR, 8'hff, 8'(nfifo));
    rd(FIFO_WRITE_POINTER_HIGH_ADDR, 8'h3f, 8'(nfifo >> 8));
    for (int b = 0; b < 2; b++) begin
      fire(5'h10);
      rd(ERROR_STATUS_ADDR, 8'h20, 8'h00);
      udma = 1'b1;
      fire(5'h10);
      rd(ERROR_STATUS_ADDR, 8'h20, 8'h20);
      rd(ERROR_STATUS_ADDR, 8'h20, 8'h20);
      nbytes = 3'd6;
      fire(5'h08);
      rd(ERROR_STATUS_ADDR, 8'h10, 8'h00);
      nbytes = 3'd1;
      fire(5'h08);
      rd(ERROR_STATUS_ADDR, 8'h10, 8'h10);
      wr(CONFIG_ADDR, (b == 0) ? 8'h01 : 8'h02);
      chk("soft_reset_pulse", 16'(b == 0), 16'(srp));
      chk("transfer_start_ctl", 16'(b != 0), 16'(tsc));
      rd(ERROR_STATUS_ADDR, 8'h30, 8'h00);
      fire(5'h04);
      udma = 1'b0;
    end
    udma = 1'b1;
    fire(5'h02);
    excess = 1'b1;
    n0 = acc;
    n1 = nfifo;
    en = 1'b1;
    repeat (30) @(negedge clk);
    en = 1'b0;
    repeat (4) @(negedge clk);
    rd(ERROR_STATUS_ADDR, 8'h40, 8'h40);
    rd(EXCESS_WORD_COUNT_ADDR, 8'hff, 8'(acc - n0));
    chk("crc_count", 16'(acc), 16'(crcn));
    chk("fifo_in_excess", 16'(n1), 16'(nfifo));
    fire(5'h01);
    excess = 1'b0;
    wr(CONFIG_ADDR, 8'h02);
    rd(ERROR_STATUS_ADDR, 8'h40, 8'h00);
    rd(EXCESS_WORD_COUNT_ADDR, 8'hff, 8'h00);
    tally_and_finish();
  end
endmodule
